/* verilog/kbr_pkg.sv */
// Constants and types shared by the keyboard serial handshake receiver
package kbr_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_PERIOD_NS = 8;
    localparam int unsigned PHASE2_PERIOD_NS = 200;
    localparam int unsigned PHASE2_CYCLES = PHASE2_PERIOD_NS / SYS_CLK_PERIOD_NS;
    localparam logic [7:0] PHASE2_LAST = 8'(PHASE2_CYCLES - 1);
    // ------------------------------------------------------------
    // Frame
    // ------------------------------------------------------------
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned STOP_BITS = 1;
    localparam int unsigned FRAME_BITS = DATA_BITS + STOP_BITS;
    localparam logic [3:0] LAST_BIT_CNT = 4'h7;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_CLEAR = 8'h0C;
    localparam logic [7:0] REG_PIC_BASE = 8'h10;
    localparam logic [7:0] REG_PIC_EOI = 8'h14;
    localparam logic [7:0] REG_PIC_REQ = 8'h18;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_ACK_GATE_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h4;
    localparam logic [7:0] PIC_BASE_RST = 8'h00;
    // Disk sync request on level 0 idles high
    localparam logic [7:0] REQ_IDLE_RST = 8'h01;
    localparam logic [2:0] KEY_IRQ_LEVEL = 3'h6;
    localparam logic [2:0] SHARED_IRQ_LEVEL = 3'h3;
    localparam logic [1:0] MODE_CODE_DATA = 2'h0;
    localparam logic [1:0] MODE_CODE_STOP_LO = 2'h1;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_DATA = 3'b001,
        MODE_STOP_LO = 3'b010,
        MODE_STOP_HI = 3'b100
    } kbr_mode_e;
    typedef enum logic [2:0] {
        PIC_IDLE = 3'b001,
        PIC_WAIT2 = 3'b010,
        PIC_SERVICE = 3'b100
    } kbr_pic_e;
    typedef struct packed {
        logic serial;
        logic strobe_n;
    } kbr_link_s;
endpackage

/* verilog/kbr_rx.sv */
// Keyboard serial handshake receiver with adapter and priority controller
//
// Contract
// - Frame is eight data bits plus stop
// - Three modes, three interrupts per byte
// - Mode 0 shifts on rising clock, irq at 8
// - Mode 1 irq on falling clock, data low
// - Mode 2 irq on rising clock, data high
// - Strobe sampled on phase two forms clock
// - Without irq acknowledge follows keyboard clock
// - Irq drives keypress directly, byte offered
// - Keypress enters controller at level six
// - Low stop irq with gate low acknowledges
// - High stop irq with gate low acknowledges
// - Wrong stop levels give no irq, acknowledge
// - Irq release with clock high drives acknowledge high
// - Two acknowledge cycles, second gives type
// - Latched requests served highest priority first
// - Level three is OR of adapters
// - Acknowledge clears chip select enable
`timescale 1ns/1ps
`default_nettype none
module kbr_rx
    import kbr_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic KEY_SERIAL_IN,
    input wire logic KEY_STROBE_N_IN,
    output logic KEY_HANDSHAKE_ACK_OUT,
    output logic KEYPRESS_IRQ_OUT,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    input wire logic [7:0] IRQ_REQ_IN,
    input wire logic ADAPTER_IRQ_IN,
    input wire logic INTA_IN,
    input wire logic ALE_IN,
    output logic CPU_INTR_OUT,
    output logic [7:0] TYPE_BYTE_OUT,
    output logic TYPE_VALID_OUT,
    output logic CS_ENABLE_OUT
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic kbr_mode_e mode_of(input logic [1:0] code);
        kbr_mode_e m;
        m = MODE_STOP_HI;
        if (code == MODE_CODE_DATA) begin
            m = MODE_DATA;
        end else if (code == MODE_CODE_STOP_LO) begin
            m = MODE_STOP_LO;
        end
        return m;
    endfunction

    function automatic logic [2:0] top_level(input logic [7:0] req);
        logic [2:0] lvl;
        lvl = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                lvl = 3'(i);
            end
        end
        return lvl;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    kbr_link_s pin_s1_q, pin_s2_q, pin_s3_q, link_q;
    logic [7:0] req_s1_q, req_s2_q, req_s3_q, req_lvl_q;
    logic adp_s1_q, adp_s2_q, adp_s3_q, adp_lvl_q;

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            pin_s3_q <= '1;
            link_q <= '1;
            req_s1_q <= REQ_IDLE_RST;
            req_s2_q <= REQ_IDLE_RST;
            req_s3_q <= REQ_IDLE_RST;
            req_lvl_q <= REQ_IDLE_RST;
            adp_s1_q <= 1'b0;
            adp_s2_q <= 1'b0;
            adp_s3_q <= 1'b0;
            adp_lvl_q <= 1'b0;
        end else begin
            pin_s1_q <= '{serial: KEY_SERIAL_IN, strobe_n: KEY_STROBE_N_IN};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            req_s1_q <= IRQ_REQ_IN;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            adp_s1_q <= ADAPTER_IRQ_IN;
            adp_s2_q <= adp_s1_q;
            adp_s3_q <= adp_s2_q;
            if (pin_s2_q.serial == pin_s3_q.serial) begin
                link_q.serial <= pin_s3_q.serial;
            end
            if (pin_s2_q.strobe_n == pin_s3_q.strobe_n) begin
                link_q.strobe_n <= pin_s3_q.strobe_n;
            end
            for (int i = 0; i < 8; i++) begin
                if (req_s2_q[i] == req_s3_q[i]) begin
                    req_lvl_q[i] <= req_s3_q[i];
                end
            end
            if (adp_s2_q == adp_s3_q) begin
                adp_lvl_q <= adp_s3_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Phase two enable and keyboard clock
    // ------------------------------------------------------------
    logic [7:0] ph2_cnt_q;
    logic kclk_q, kclk_prev_q;
    wire ph2_en = (ph2_cnt_q == PHASE2_LAST);
    wire kclk_rise = kclk_q & ~kclk_prev_q;
    wire kclk_fall = ~kclk_q & kclk_prev_q;

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            ph2_cnt_q <= 8'h00;
            kclk_q <= 1'b1;
            kclk_prev_q <= 1'b1;
        end else begin
            ph2_cnt_q <= ph2_en ? 8'h00 : ph2_cnt_q + 8'h01;
            if (ph2_en) begin
                kclk_q <= link_q.strobe_n;
            end
            kclk_prev_q <= kclk_q;
        end
    end

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [2:0] ctrl_q;
    logic [7:0] pic_base_q;
    wire wr_ctrl = REG_WR_IN & (REG_ADDR_IN == REG_CTRL);
    wire wr_clear = REG_WR_IN & (REG_ADDR_IN == REG_CLEAR);
    wire wr_base = REG_WR_IN & (REG_ADDR_IN == REG_PIC_BASE);
    wire wr_eoi = REG_WR_IN & (REG_ADDR_IN == REG_PIC_EOI);
    wire rd_data = REG_RD_IN & (REG_ADDR_IN == REG_DATA);
    wire ack_gate = ctrl_q[CTRL_ACK_GATE_BIT];
    kbr_mode_e mode;
    assign mode = mode_of(ctrl_q[CTRL_MODE_LSB +: 2]);

    // ------------------------------------------------------------
    // Adapter: shift register and stop checks
    // ------------------------------------------------------------
    logic [7:0] shift_q, byte_q;
    logic [3:0] bit_cnt_q;
    logic irq_q, ack_q;
    wire shift_now = (mode == MODE_DATA) & kclk_rise;
    wire byte_done = shift_now & (bit_cnt_q == LAST_BIT_CNT);
    wire stop_lo_ok = (mode == MODE_STOP_LO) & kclk_fall & ~link_q.serial;
    wire stop_hi_ok = (mode == MODE_STOP_HI) & kclk_rise & link_q.serial;
    wire irq_set = byte_done | stop_lo_ok | stop_hi_ok;
    wire irq_clr = wr_clear | rd_data;
    wire ack_d = irq_q ? ack_gate : kclk_q;

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            ctrl_q <= CTRL_RST;
            pic_base_q <= PIC_BASE_RST;
            shift_q <= 8'h00;
            byte_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            irq_q <= 1'b0;
            ack_q <= 1'b1;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= REG_WDATA_IN[2:0];
            end
            if (wr_base) begin
                pic_base_q <= REG_WDATA_IN[7:0];
            end
            if (wr_ctrl) begin
                bit_cnt_q <= 4'h0;
            end else if (shift_now) begin
                shift_q <= {shift_q[6:0], link_q.serial};
                bit_cnt_q <= byte_done ? 4'h0 : bit_cnt_q + 4'h1;
            end
            if (byte_done) begin
                byte_q <= {shift_q[6:0], link_q.serial};
            end
            irq_q <= irq_set | (irq_q & ~irq_clr);
            ack_q <= ack_d;
        end
    end

    assign KEY_HANDSHAKE_ACK_OUT = ack_q;
    assign KEYPRESS_IRQ_OUT = irq_q;

    // ------------------------------------------------------------
    // Priority controller
    // ------------------------------------------------------------
    logic [7:0] req_q, src_prev_q;
    logic [2:0] lvl_q;
    logic cs_en_q, type_vld_q;
    logic [7:0] type_q;
    kbr_pic_e pic_q;
    wire shared_src = adp_lvl_q | irq_q | req_lvl_q[3];
    logic [7:0] src;
    assign src = {req_lvl_q[7], irq_q, req_lvl_q[5:4], shared_src, req_lvl_q[2:0]};
    wire [7:0] src_rise = src & ~src_prev_q;
    wire [2:0] pick = top_level(req_q);
    wire take1 = (pic_q == PIC_IDLE) & INTA_IN & (|req_q);
    wire take2 = (pic_q == PIC_WAIT2) & INTA_IN;
    wire [7:0] clr_mask = take1 ? 8'(8'h01 << pick) : 8'h00;

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            req_q <= 8'h00;
            src_prev_q <= REQ_IDLE_RST;
            lvl_q <= 3'h0;
            pic_q <= PIC_IDLE;
            type_q <= 8'h00;
            type_vld_q <= 1'b0;
            cs_en_q <= 1'b0;
        end else begin
            src_prev_q <= src;
            req_q <= src_rise | (req_q & ~clr_mask);
            type_vld_q <= take2;
            if (INTA_IN) begin
                cs_en_q <= 1'b0;
            end else if (ALE_IN) begin
                cs_en_q <= 1'b1;
            end
            case (pic_q)
                PIC_IDLE: begin
                    if (take1) begin
                        lvl_q <= pick;
                        pic_q <= PIC_WAIT2;
                    end
                end
                PIC_WAIT2: begin
                    if (take2) begin
                        type_q <= pic_base_q + {5'h00, lvl_q};
                        pic_q <= PIC_SERVICE;
                    end
                end
                PIC_SERVICE: begin
                    if (wr_eoi) begin
                        pic_q <= PIC_IDLE;
                    end
                end
                default: begin
                    pic_q <= PIC_IDLE;
                end
            endcase
        end
    end

    assign CPU_INTR_OUT = (pic_q == PIC_IDLE) & (|req_q);
    assign TYPE_BYTE_OUT = type_q;
    assign TYPE_VALID_OUT = type_vld_q;
    assign CS_ENABLE_OUT = cs_en_q;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;
    assign rd_mux = (REG_ADDR_IN == REG_CTRL) ? {29'h0, ctrl_q} :
                    (REG_ADDR_IN == REG_STATUS) ? {20'h0, bit_cnt_q, ack_q, kclk_q, link_q.serial, irq_q, 1'b0, mode} :
                    (REG_ADDR_IN == REG_DATA) ? {24'h0, byte_q} :
                    (REG_ADDR_IN == REG_PIC_BASE) ? {24'h0, pic_base_q} :
                    (REG_ADDR_IN == REG_PIC_REQ) ? {21'h0, pic_q, req_q} : 32'h0000_0000;

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= REG_RD_IN ? rd_mux : 32'h0000_0000;
        end
    end

    assign REG_RDATA_OUT = rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    chk_sync_clock: assert property (ph2_en && !link_q.strobe_n |=> !kclk_q)
        else $error("keyboard clock not low after strobe sampled low");
    chk_ack_follow: assert property (!irq_q && !kclk_q |=> !KEY_HANDSHAKE_ACK_OUT)
        else $error("acknowledge did not follow keyboard clock low");
    chk_byte_irq: assert property (shift_now && bit_cnt_q == 4'h7 |=> KEYPRESS_IRQ_OUT)
        else $error("no interrupt after eighth bit");
    chk_stop_low: assert property (mode == MODE_STOP_LO && kclk_fall && !link_q.serial |=> irq_q)
        else $error("low stop phase gave no interrupt");
    chk_stop_high: assert property (mode == MODE_STOP_HI && kclk_rise && link_q.serial |=> irq_q)
        else $error("high stop phase gave no interrupt");
    chk_stop_bad: assert property (mode == MODE_STOP_LO && !irq_q && !(kclk_fall && !link_q.serial) |=> !irq_q)
        else $error("interrupt raised on wrong stop levels");
    chk_stop_ack: assert property (irq_q && !ack_gate ##1 irq_q |-> !KEY_HANDSHAKE_ACK_OUT)
        else $error("gated acknowledge not low during interrupt");
    chk_irq_release: assert property ($fell(irq_q) && kclk_q |=> KEY_HANDSHAKE_ACK_OUT)
        else $error("acknowledge not high after interrupt release");
    chk_type_byte: assert property (take2 |=> TYPE_VALID_OUT && TYPE_BYTE_OUT == $past(pic_base_q) + {5'h00, $past(lvl_q)})
        else $error("type byte wrong on second acknowledge");
    chk_cs_clear: assert property (INTA_IN |=> !CS_ENABLE_OUT)
        else $error("chip select enable not cleared by acknowledge");
    chk_key_level: assert property ($rose(irq_q) && !INTA_IN && !$past(shared_src) |=> req_q[6] && req_q[3])
        else $error("keypress not latched at levels six and three");
    chk_rdata_slot: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0000_0000)
        else $error("read data outside its cycle");
    chk_ack_high: assert property (!irq_q && kclk_q |=> KEY_HANDSHAKE_ACK_OUT)
        else $error("acknowledge did not follow keyboard clock high");
    chk_stop_hi_ack: assert property (stop_hi_ok ##1 !ack_gate |=> !KEY_HANDSHAKE_ACK_OUT)
        else $error("high stop phase not acknowledged");
    chk_stop_bad_hi: assert property (mode == MODE_STOP_HI && !irq_q && !(kclk_rise && link_q.serial) |=> !irq_q)
        else $error("interrupt raised on wrong high stop levels");

    cov_byte: cover property (byte_done);
    cov_stop_lo: cover property (stop_lo_ok);
    cov_stop_hi: cover property (stop_hi_ok);
    cov_type: cover property (TYPE_VALID_OUT);
    cov_stop_bad: cover property (mode == MODE_STOP_LO && kclk_fall && link_q.serial);
endmodule
`default_nettype wire

/* verif/kbr_kbd_model.sv */
// Behavioural keyboard that sends frames over the handshake link
`timescale 1ns/1ps
`default_nettype none
module kbr_kbd_model
    import kbr_pkg::*;
(
    input wire logic lclk_in,
    input wire logic ack_in,
    output var kbr_link_s link_out,
    output var logic fault_out
);
    initial begin
        link_out = 2'h3;
        fault_out = 1'h0;
    end
    // Bounded wait for an acknowledge level
    task automatic wait_ack(input logic lvl);
        int i;
        for (i = 0; i < 400 && ack_in !== lvl; i++) begin
            @(posedge lclk_in);
        end
        if (ack_in !== lvl) begin
            fault_out = 1'h1;
        end
    endtask
    // Eight bits, first bit is the top bit, then low and high stop phases
    task automatic send(input logic [7:0] b, input logic good_stop);
        int i;
        for (i = 7; i >= 0; i--) begin
            @(posedge lclk_in);
            link_out.serial = b[i];
            @(posedge lclk_in);
            link_out.strobe_n = 1'h0;
            wait_ack(1'h0);
            @(posedge lclk_in);
            link_out.strobe_n = 1'h1;
            wait_ack(1'h1);
        end
        repeat (40) @(posedge lclk_in);
        link_out.serial = ~good_stop;
        @(posedge lclk_in);
        link_out.strobe_n = 1'h0;
        wait_ack(1'h0);
        repeat (2) @(posedge lclk_in);
        link_out = 2'h3;
        wait_ack(1'h1);
    endtask
endmodule
`default_nettype wire

/* verif/tb_kbr_rx.sv */
// Self-checking bench for the keyboard serial handshake receiver
`timescale 1ns/1ps
`default_nettype none
module tb_kbr_rx
    import kbr_pkg::*;
;
    logic clk, rst, lclk, wr, rd, inta, ale, adp, done, ack, kirq, intr, tvalid, csen, kfault;
    logic [7:0] addr, irqs, tbyte;
    logic [31:0] wdata, rdata, d;
    kbr_link_s link;
    int n_fail, comparisons;
    always #4 clk = ~clk;
    initial begin
        lclk = 1'h0;
        #3;
        forever #32 lclk = ~lclk;
    end
    kbr_rx dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .KEY_SERIAL_IN(link.serial),
        .KEY_STROBE_N_IN(link.strobe_n), .KEY_HANDSHAKE_ACK_OUT(ack), .KEYPRESS_IRQ_OUT(kirq),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .IRQ_REQ_IN(irqs), .ADAPTER_IRQ_IN(adp), .INTA_IN(inta), .ALE_IN(ale), .CPU_INTR_OUT(intr),
        .TYPE_BYTE_OUT(tbyte), .TYPE_VALID_OUT(tvalid), .CS_ENABLE_OUT(csen));
    kbr_kbd_model kbd (.lclk_in(lclk), .ack_in(ack), .link_out(link), .fault_out(kfault));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(posedge clk);
        v = rdata;
    endtask
    task automatic pulse(input bit is_inta);
        @(posedge clk);
        if (is_inta) inta <= 1'h1;
        else ale <= 1'h1;
        @(posedge clk);
        inta <= 1'h0;
        ale <= 1'h0;
    endtask
    task automatic wait_irq(input logic lvl, input int lim);
        int i;
        @(posedge clk);
        for (i = 0; i < lim && kirq !== lvl; i++) begin
            @(posedge clk);
        end
        if (kirq !== lvl) begin
            chk("keypress irq wait", 32'(lvl), 32'(kirq));
            tally_and_finish();
        end
    endtask
    // Select, two acknowledges, end of service
    task automatic serve(input logic [7:0] exp);
        chk("cpu intr", 32'h1, 32'(intr));
        pulse(0);
        @(posedge clk);
        chk("cs enable set", 32'h1, 32'(csen));
        pulse(1);
        @(posedge clk);
        chk("cs enable cleared", 32'h0, 32'(csen));
        pulse(1);
        @(posedge clk);
        chk("type valid", 32'h1, 32'(tvalid));
        chk("type byte", 32'(exp), 32'(tbyte));
        reg_wr(REG_PIC_EOI, 32'h0);
        repeat (2) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("ack idle", 32'h1, 32'(ack));
        chk("idle outputs", 32'h0, {29'h0, kirq, intr, csen});
        reg_rd(REG_STATUS, d);
        chk("status idle", 32'h0000_00E1, d & 32'h0000_00F7);
        reg_rd(REG_CTRL, d);
        chk("ctrl reset", 32'(CTRL_RST), d);
        reg_rd(REG_PIC_BASE, d);
        chk("pic base reset", 32'(PIC_BASE_RST), d);
        reg_rd(8'h1C, d);
        chk("unmapped read", 32'h0, d);
        reg_wr(REG_PIC_BASE, 32'h0000_0040);
    endtask
    task automatic t_good(input logic pressed, input logic [6:0] key);
        logic [7:0] b;
        b = {pressed, key};
        fork
            kbd.send(b, 1'h1);
            begin
                wait_irq(1'h1, 5000);
                reg_rd(REG_DATA, d);
                chk("data byte", 32'(b), d);
                reg_wr(REG_CTRL, 32'h0000_0001);
                wait_irq(1'h1, 5000);
                @(posedge clk);
                chk("ack stop low", 32'h0, 32'(ack));
                reg_wr(REG_CTRL, 32'h0000_0002);
                reg_wr(REG_CLEAR, 32'h0);
                wait_irq(1'h1, 2000);
                reg_rd(REG_STATUS, d);
                chk("status stop high", 32'h0000_0014, d & 32'h0000_001F);
                chk("ack stop high", 32'h0, 32'(ack));
                reg_wr(REG_CLEAR, 32'h0);
                repeat (3) @(posedge clk);
                chk("ack release", 32'h1, 32'(ack));
            end
        join
        chk("keyboard handshake", 32'h0, 32'(kfault));
        reg_wr(REG_CTRL, 32'(CTRL_RST));
    endtask
    task automatic t_bad(input logic [7:0] b);
        int i, n;
        done = 1'h0;
        n = 0;
        fork
            begin
                kbd.send(b, 1'h0);
                done = 1'h1;
            end
            begin
                wait_irq(1'h1, 5000);
                reg_rd(REG_DATA, d);
                chk("data byte", 32'(b), d);
                reg_wr(REG_CTRL, 32'h0000_0001);
                for (i = 0; i < 8000 && !done; i++) begin
                    @(posedge clk);
                    if (kirq !== 1'h0) n++;
                end
                chk("bad frame finished", 32'h1, 32'(done));
                chk("irq on wrong stop", 32'h0, 32'(n));
            end
        join
        chk("ack follows clock", 32'h0, 32'(kfault));
        reg_wr(REG_CTRL, 32'(CTRL_RST));
    endtask
    task automatic t_pic_ext();
        irqs <= 8'h41;
        repeat (10) @(posedge clk);
        chk("level six line ignored", 32'h0, 32'(intr));
        irqs <= 8'h40;
        repeat (4) @(posedge clk);
        irqs <= 8'h41;
        adp <= 1'h1;
        repeat (10) @(posedge clk);
        reg_rd(REG_PIC_REQ, d);
        chk("pending requests", 32'h0000_0109, d);
        serve(8'h40);
        serve(8'h43);
        chk("no request left", 32'h0, 32'(intr));
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'h0;
        rst = 1'h1;
        {wr, rd, inta, ale, adp, done} = 6'h0;
        addr = 8'h0;
        wdata = 32'h0;
        irqs = 8'h01;
        n_fail = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_good(1'h1, 7'h2A);
        t_good(1'h0, 7'h15);
        t_bad(8'hC3);
        serve(8'h43);
        serve(8'h46);
        chk("requests served", 32'h0, 32'(intr));
        t_pic_ext();
        tally_and_finish();
    end
endmodule
`default_nettype wire
